// ==== design/dos_consts.vh ====
`ifndef DOS_CONSTS_VH
`define DOS_CONSTS_VH

// register byte offsets on the apb bus
`define DOS_OFF_CTRL      8'h00
`define DOS_OFF_STAT      8'h04
`define DOS_OFF_DIV       8'h08
`define DOS_OFF_DATA0     8'h0c
`define DOS_OFF_DATA1     8'h10
`define DOS_OFF_FIFO      8'h14
`define DOS_OFF_RANGE     8'h18

// control register fields; bits 8..10 are write-one actions
`define DOS_CTRL_CONT0    0
`define DOS_CTRL_CONT1    1
`define DOS_CTRL_EXTCLK   2
`define DOS_CTRL_TRGFALL  3
`define DOS_CTRL_WAVE     4
`define DOS_CTRL_SYNC     5
`define DOS_CTRL_FINITE   6
`define DOS_CTRL_START    8
`define DOS_CTRL_STOP     9
`define DOS_CTRL_CLR      10
`define DOS_CTRL_W        7
`define DOS_CTRL_RST      7'h00

// status register fields
`define DOS_STAT_EMPTY    3
`define DOS_STAT_FULL     4
`define DOS_STAT_REFILL   5
`define DOS_STAT_UNDER    6
`define DOS_STAT_LVL_LSB  16

// range register: 3-bit field per channel
`define DOS_RNG0_LSB      0
`define DOS_RNG1_LSB      4
`define DOS_RNG_W         3
`define DOS_RNG_U5        3'h0
`define DOS_RNG_U10       3'h1
`define DOS_RNG_B5        3'h2
`define DOS_RNG_B10       3'h3
`define DOS_RNG_EXTU      3'h4
`define DOS_RNG_EXTB      3'h5
`define DOS_RNG_RST       3'h0

// converter code: straight binary, reset to range bottom
`define DOS_CODE_W        12
`define DOS_CODE_RST      12'h000

// timing
`define DOS_PCLK_HZ       10000000
`define DOS_TB_HZ         20000000
`define DOS_MAX_SPS       250000
`define DOS_DIV_RST       32'h0000_0050

`endif

// ==== design/dos_insync.v ====
// three-stage pin synchroniser with a stability filter
module dos_insync (
  input  wire pclk,
  input  wire presetn,
  input  wire pin,
  output reg  rise_q,
  output reg  fall_q
);
  reg s1_q;   // metastability catch, read by s2_q only
  reg s2_q;   // second stage
  reg s3_q;   // third stage
  reg lvl_q;  // filtered level

  // a change counts once the second and third stage agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (s2_q == s3_q && s2_q != lvl_q) begin
        lvl_q  <= s2_q;
        rise_q <= s2_q;
        fall_q <= ~s2_q;
      end
    end
  end
endmodule

// ==== design/dos_top.v ====
// Contract
// R1 - two channels, each taking 12-bit codes
// R2 - mode chosen separately per channel
// R3 - single value write updates output at once
// R4 - update rate capped at 250k samples per second
// R5 - host sets clock, trigger, then fills buffer
// R6 - after trigger, one sample per pace tick
// R7 - request refill as buffer level drops
// R8 - run until buffer drained or stopped
// R9 - even addresses to channel 0, odd to 1
// R10 - waveform mode replays pattern without gaps
// R11 - waveform samples emitted at pacing rate
// R12 - sync mode: all channels update together
// R13 - sync rate is pace over active channels
// R14 - pacer divides 20 MHz by 32-bit count
// R15 - internal pace on divider rising edge
// R16 - external pace on rising edge, max 250k
// R17 - trigger edge on pin, polarity selectable
// R18 - trigger gates only continuous channels
// R19 - codes are straight binary to converter
// R20 - per-channel range selection register
// R21 - empty buffer holds last code
`include "dos_consts.vh"

module dos_top #(
  parameter DEPTH    = 1024,  // sample buffer depth, power of two
  parameter AW       = 10,    // buffer address width
  parameter LOW_MARK = 512    // refill request level
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ext_pace,
  input  wire        ext_trig,
  output wire [11:0] dac0_code,
  output wire [11:0] dac1_code,
  output wire        dac0_load,
  output wire        dac1_load,
  output wire [2:0]  range0,
  output wire [2:0]  range1,
  output wire        refill_req,
  output wire        busy
);
  // sequencer states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARM  = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  // 20 MHz ticks per pclk; the time base must be a multiple of pclk
  localparam integer STEP_I = `DOS_TB_HZ / `DOS_PCLK_HZ;
  localparam [32:0]  STEP   = {1'b0, STEP_I[31:0]};
  // least pclk cycles between two pace ticks, rounded up
  localparam integer GAP_I  =
    (`DOS_PCLK_HZ + `DOS_MAX_SPS - 1) / `DOS_MAX_SPS;
  localparam [7:0]   GAP    = GAP_I[7:0];
  localparam [AW:0]  FULL_L = DEPTH[AW:0];
  localparam [AW:0]  LOW_L  = LOW_MARK[AW:0];

  // address decode, shared by error answer and write
  function hit;
    input [7:0] a;
    begin
      case (a)
        `DOS_OFF_CTRL, `DOS_OFF_STAT, `DOS_OFF_DIV,
        `DOS_OFF_DATA0, `DOS_OFF_DATA1, `DOS_OFF_FIFO,
        `DOS_OFF_RANGE: hit = 1'b1;
        default:        hit = 1'b0;
      endcase
    end
  endfunction

  reg [`DOS_CTRL_W-1:0] ctrl_q;      // mode and source settings
  reg [31:0]            div_q;       // pacer divisor in 20 MHz ticks
  reg [5:0]             range_q;     // both range fields
  reg [2:0]             state_q;     // sequencer state
  reg [2:0]             state_d;     // its next value
  reg [32:0]            acc_q;       // divider accumulator
  reg                   tick_d;      // divider rising edge this cycle
  reg [32:0]            acc_d;       // next accumulator
  reg [7:0]             gap_q;       // cycles since last accepted tick
  reg [AW-1:0]          wr_ptr_q;    // buffer write address
  reg [AW-1:0]          rd_ptr_q;    // buffer read address
  reg [AW:0]            cnt_q;       // samples held
  reg                   under_q;     // sticky underrun flag
  reg [31:0]            prdata_q;    // read data, loaded in setup
  wire [23:0]           code_q;      // both converter codes
  wire [1:0]            load_q;      // converter update strobes
  reg [AW-1:0]          rd_next;     // next read address
  reg [`DOS_CODE_W-1:0] mem [0:DEPTH-1];  // sample buffer

  wire trig_rise;   // filtered trigger pin edges
  wire trig_fall;
  wire pace_rise;   // filtered external pace edge

  // trigger and external pace pins come from outside the clock domain
  dos_insync u_trig (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_trig),
    .rise_q  (trig_rise),
    .fall_q  (trig_fall)
  );

  dos_insync u_pace (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_pace),
    .rise_q  (pace_rise),
    .fall_q  ()
  );

  // bus strobes; the slave never waits
  wire acc_ph  = psel & penable;
  wire wr_en   = acc_ph & pwrite & hit(paddr);
  wire rd_set  = psel & ~penable & ~pwrite;
  wire wr_ctrl = wr_en & (paddr == `DOS_OFF_CTRL);
  wire start_w = wr_ctrl & pwdata[`DOS_CTRL_START];
  wire stop_w  = wr_ctrl & pwdata[`DOS_CTRL_STOP];
  wire clr_w   = wr_ctrl & pwdata[`DOS_CTRL_CLR];
  wire push    = wr_en & (paddr == `DOS_OFF_FIFO) & (cnt_q != FULL_L);

  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit(paddr);
  assign prdata  = prdata_q;

  // mode bits
  wire cont0  = ctrl_q[`DOS_CTRL_CONT0];                   // [R2]
  wire cont1  = ctrl_q[`DOS_CTRL_CONT1];                   // [R2]
  wire both   = cont0 & cont1;
  wire extclk = ctrl_q[`DOS_CTRL_EXTCLK];
  wire wave   = ctrl_q[`DOS_CTRL_WAVE];
  wire sync   = ctrl_q[`DOS_CTRL_SYNC];
  wire empty  = (cnt_q == {(AW+1){1'b0}});
  wire run    = (state_q == ST_RUN);

  // trigger edge polarity is software selected
  wire trig_evt = ctrl_q[`DOS_CTRL_TRGFALL] ? trig_fall
                                            : trig_rise;   // [R17]

  // pace source: divider edge or external rising edge
  wire pace_evt = extclk ? pace_rise : tick_d;             // [R15] [R16]
  // ticks closer than the rate limit are dropped
  wire pace_ok  = run & pace_evt & (gap_q >= GAP);          // [R4] [R16]
  // an empty buffer produces no update, outputs hold
  wire pop      = pace_ok & ~empty;                         // [R6] [R21]

  // with both channels the address parity picks the target
  wire tgt1 = both ? rd_ptr_q[0] : cont1;                   // [R9]
  wire [`DOS_CODE_W-1:0] sample = mem[rd_ptr_q];
  // in sync mode the last active channel releases all
  wire upd_all = pop & sync & (~both | tgt1);               // [R12] [R13]

  assign refill_req = run & ~wave & (cnt_q <= LOW_L);       // [R7]
  assign busy       = ~state_q[0];

  // internal pacer: 20 MHz time base divided by a 32-bit count
  always @* begin
    acc_d  = acc_q + STEP;
    tick_d = 1'b0;
    if (state_q == ST_IDLE || extclk || div_q == 32'h0000_0000) begin
      acc_d = 33'h0_0000_0000;
    end else if (acc_d >= {1'b0, div_q}) begin
      acc_d  = acc_d - {1'b0, div_q};                       // [R14]
      tick_d = 1'b1;                                        // [R15]
    end
  end

  // read address: waveform mode wraps over the loaded pattern
  always @* begin
    rd_next = rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
    if (wave && ({1'b0, rd_ptr_q} + {{AW{1'b0}}, 1'b1}) == cnt_q) begin
      rd_next = {AW{1'b0}};                                 // [R10]
    end
  end

  // sequencer: idle, armed waiting for trigger, running
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // the mode written with start decides; stop beside it wins
        if (start_w && !stop_w &&
            (pwdata[`DOS_CTRL_CONT0] || pwdata[`DOS_CTRL_CONT1])) begin
          state_d = ST_ARM;                                 // [R18]
        end
      end
      ST_ARM: begin
        if (stop_w) begin
          state_d = ST_IDLE;
        end else if (trig_evt) begin
          state_d = ST_RUN;                                 // [R6] [R11]
        end
      end
      ST_RUN: begin
        if (stop_w || !(cont0 || cont1)) begin
          state_d = ST_IDLE;                                // [R8]
        end else if (ctrl_q[`DOS_CTRL_FINITE] && !wave && empty) begin
          // finite run ends once every buffered sample is out
          state_d = ST_IDLE;                                // [R8]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // control registers, pacer and rate limiter state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `DOS_CTRL_RST;
      div_q   <= `DOS_DIV_RST;
      range_q <= {`DOS_RNG_RST, `DOS_RNG_RST};
      state_q <= ST_IDLE;
      acc_q   <= 33'h0_0000_0000;
      gap_q   <= 8'h00;
      under_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      if (wr_ctrl) begin
        ctrl_q <= pwdata[`DOS_CTRL_W-1:0];                  // [R2] [R5]
      end
      if (wr_en && paddr == `DOS_OFF_DIV) begin
        div_q <= pwdata;                                    // [R14]
      end
      if (wr_en && paddr == `DOS_OFF_RANGE) begin
        range_q <= {pwdata[`DOS_RNG1_LSB +: `DOS_RNG_W],
                    pwdata[`DOS_RNG0_LSB +: `DOS_RNG_W]};   // [R20]
      end
      // first tick after arming is never held back
      if (!run || pace_ok) begin
        gap_q <= run ? 8'h01 : GAP;
      end else if (gap_q < GAP) begin
        gap_q <= gap_q + 8'h01;
      end
      // underrun: a set in the same cycle as a clear wins
      if (pace_ok && empty) begin
        under_q <= 1'b1;                                    // [R21]
      end else if (wr_en && paddr == `DOS_OFF_STAT &&
                   pwdata[`DOS_STAT_UNDER]) begin
        under_q <= 1'b0;
      end
    end
  end

  // sample buffer pointers and fill level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
    end else if (clr_w) begin
      // clear restarts the buffer; a pattern must be loaded after it
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_next;                                // [R9] [R10]
      end
      // waveform playback reads without consuming
      if (push && !(pop && !wave)) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (!push && pop && !wave) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};                // [R8]
      end
    end
  end

  // buffer storage has no reset; contents are only read when counted
  always @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_q] <= pwdata[`DOS_CODE_W-1:0];             // [R1]
    end
  end

  // per-channel output path
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      wire        cont_i = ctrl_q[`DOS_CTRL_CONT0 + i];
      wire        me_i   = (i == 1) ? tgt1 : ~tgt1;
      wire [7:0]  doff_i = (i == 1) ? `DOS_OFF_DATA1 : `DOS_OFF_DATA0;
      // single value writes bypass trigger and pacing entirely
      wire        sv_i   = wr_en & (paddr == doff_i) & ~cont_i;
      reg  [11:0] ch_code_q;   // this converter's code
      reg  [11:0] ch_stage_q;  // its sync-mode holding value
      reg         ch_load_q;   // its update strobe
      wire [11:0] new_i  = (pop & me_i) ? sample : ch_stage_q;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_code_q  <= `DOS_CODE_RST;
          ch_stage_q <= `DOS_CODE_RST;
          ch_load_q  <= 1'b0;
        end else begin
          ch_load_q <= 1'b0;
          if (sv_i) begin
            ch_code_q <= pwdata[`DOS_CODE_W-1:0];           // [R3] [R18]
            ch_load_q <= 1'b1;                              // [R3]
          end else if (pop && me_i && !sync) begin
            ch_code_q <= sample;                            // [R6] [R11]
            ch_load_q <= 1'b1;
          end else if (upd_all && cont_i) begin
            // every active converter loads together; the releasing one takes the current sample
            ch_code_q <= new_i;                             // [R12]
            ch_load_q <= 1'b1;                              // [R12]
          end
          if (pop && me_i) begin
            ch_stage_q <= sample;                           // [R12]
          end
        end
      end
      // one driver per register; the shared words are only wiring
      assign code_q[12*i +: 12] = ch_code_q;
      assign load_q[i]          = ch_load_q;
    end
  endgenerate

  // codes go out unchanged: straight binary
  assign dac0_code = code_q[11:0];                          // [R19]
  assign dac1_code = code_q[23:12];                         // [R19]
  assign dac0_load = load_q[0];
  assign dac1_load = load_q[1];
  assign range0    = range_q[2:0];                          // [R20]
  assign range1    = range_q[5:3];                          // [R20]

  // read data is captured in the setup cycle, no read side effects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_set) begin
      prdata_q <= 32'h0000_0000;
      case (paddr)
        `DOS_OFF_CTRL:  prdata_q[`DOS_CTRL_W-1:0] <= ctrl_q;
        `DOS_OFF_STAT: begin
          prdata_q[2:0]              <= state_q;
          prdata_q[`DOS_STAT_EMPTY]  <= empty;
          prdata_q[`DOS_STAT_FULL]   <= (cnt_q == FULL_L);
          prdata_q[`DOS_STAT_REFILL] <= refill_req;
          prdata_q[`DOS_STAT_UNDER]  <= under_q;
          prdata_q[`DOS_STAT_LVL_LSB +: AW+1] <= cnt_q;
        end
        `DOS_OFF_DIV:   prdata_q <= div_q;
        `DOS_OFF_DATA0: prdata_q[11:0] <= code_q[11:0];
        `DOS_OFF_DATA1: prdata_q[11:0] <= code_q[23:12];
        `DOS_OFF_RANGE: begin
          prdata_q[`DOS_RNG0_LSB +: `DOS_RNG_W] <= range_q[2:0];
          prdata_q[`DOS_RNG1_LSB +: `DOS_RNG_W] <= range_q[5:3];
        end
        default:        prdata_q <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== verif/dos_top_props.sv ====
// watches the block's ports only; mode bits are mirrored from bus writes
module dos_top_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [11:0] dac0_code,
  input logic [11:0] dac1_code,
  input logic        dac0_load,
  input logic        dac1_load,
  input logic [2:0]  range0,
  input logic [2:0]  range1,
  input logic        refill_req,
  input logic        busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] ctrl_q;  // mirror of the mode bits
  logic [5:0] gap_q;   // cycles since the last paced load
  wire        ctl_wr = psel & penable & pwrite & (paddr == 8'h00);
  wire        d0_wr  = psel & penable & pwrite & (paddr == 8'h0c);
  wire        d1_wr  = psel & penable & pwrite & (paddr == 8'h10);
  wire        rng_wr = psel & penable & pwrite & (paddr == 8'h18);
  wire        pace_ev = (dac0_load & ctrl_q[0]) | (dac1_load & ctrl_q[1]);

  // action bits are not kept, only the mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= 7'h00;
    else if (ctl_wr) ctrl_q <= pwdata[6:0];
  end

  // saturates so a long pause never wraps into a false short gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 6'h3f;
    else if (pace_ev) gap_q <= 6'h00;
    else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  single_ch0_a: assert property (
    d0_wr && !ctrl_q[0] |=> dac0_load && dac0_code == $past(pwdata[11:0]))
    else $error("channel 0 single write not applied");
  single_ch1_a: assert property (
    d1_wr && !ctrl_q[1] |=> dac1_load && dac1_code == $past(pwdata[11:0]))
    else $error("channel 1 single write not applied");
  code_load_a: assert property ($changed(dac0_code) |-> dac0_load)
    else $error("code changed without load");
  load_cause_a: assert property (
    dac1_load |-> $past(busy) || $past(d1_wr))
    else $error("load without run or write");
  pace_gap_a: assert property (pace_ev |-> gap_q >= 6'd39)
    else $error("paced loads too close");
  range_wr_a: assert property (rng_wr |=>
    range0 == $past(pwdata[2:0]) && range1 == $past(pwdata[6:4]))
    else $error("range write not applied");
  refill_idle_a: assert property (!busy |-> !refill_req)
    else $error("refill request while idle");
  arm_start_a: assert property (ctl_wr && pwdata[8] && !pwdata[9]
    && pwdata[1:0] != 2'b00 && !busy |=> busy)
    else $error("start did not arm");
  no_cont_a: assert property (ctl_wr && pwdata[8]
    && pwdata[1:0] == 2'b00 && !busy |=> !busy)
    else $error("start ran with no continuous channel");
  stop_run_a: assert property (ctl_wr && pwdata[9] |-> ##[1:2] !busy)
    else $error("stop did not end the run");
endmodule

bind dos_top dos_top_props props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .dac0_code(dac0_code), .dac1_code(dac1_code), .dac0_load(dac0_load),
  .dac1_load(dac1_load), .range0(range0), .range1(range1),
  .refill_req(refill_req), .busy(busy)
);

// ==== verif/dos_ext_src.sv ====
// external pace and trigger source on the connector side
module dos_ext_src (
  input  logic pclk,
  output logic ext_pace,
  output logic ext_trig
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ext_pace = 1'b0;
    ext_trig = 1'b0;
  end
  // level held well past the pin filter so the edge is never lost
  task automatic trig_to(input logic lvl);
    @(posedge pclk);
    ext_trig <= lvl;
    repeat (6) @(posedge pclk);
  endtask
  // pulses 61 cycles apart keep the source below the rate ceiling
  task automatic pace(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_pace <= 1'b1;
      repeat (5) @(posedge pclk);
      ext_pace <= 1'b0;
      repeat (55) @(posedge pclk);
    end
  endtask
endmodule

// ==== verif/dos_top_tb_top.sv ====
module dos_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  wire         ext_pace, ext_trig;
  logic [11:0] dac0_code, dac1_code;
  logic        dac0_load, dac1_load, refill_req, busy;
  logic [2:0]  range0, range1;
  int          err_count, n_compared, seed;
  logic [11:0] exp0[$], exp1[$];  // expected codes per channel
  logic [11:0] s[4];

  // small buffer so the refill level is reached with few samples
  dos_top #(.DEPTH(16), .AW(4), .LOW_MARK(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_pace(ext_pace),
    .ext_trig(ext_trig), .dac0_code(dac0_code), .dac1_code(dac1_code),
    .dac0_load(dac0_load), .dac1_load(dac1_load), .range0(range0),
    .range1(range1), .refill_req(refill_req), .busy(busy));
  dos_ext_src src_u (.pclk(pclk), .ext_pace(ext_pace), .ext_trig(ext_trig));

  always #50 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait until every noted code has been seen
  task automatic drain;
    int i;
    for (i = 0; i < 3000 && (exp0.size() + exp1.size()) != 0; i++)
      @(posedge pclk);
    if (exp0.size() + exp1.size() != 0) begin
      err_count++;
      conclude();
    end
  endtask

  // a load with nothing noted is itself a mismatch
  always @(posedge pclk) begin
    if (presetn === 1'b1 && dac0_load === 1'b1)
      chk({20'h0, dac0_code}, exp0.size() ? {20'h0, exp0.pop_front()}
          : 32'hffff_ffff);
    if (presetn === 1'b1 && dac1_load === 1'b1)
      chk({20'h0, dac1_code}, exp1.size() ? {20'h0, exp1.pop_front()}
          : 32'hffff_ffff);
  end

  initial begin
    int k;
    logic [11:0] vals[4];
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    seed = 42;
    vals = '{12'h000, 12'h800, 12'hfff, 12'h000};
    vals[3] = 12'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(8'h1c, 1'b0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (k = 0; k < 6; k++) begin
      apb(8'h18, 1'b1, {25'h0, 3'(5 - k), 1'b0, 3'(k)});
      @(negedge pclk);
      chk({26'h0, range1, range0}, {26'h0, 3'(5 - k), 3'(k)});
    end
    // single value writes on both channels, every boundary code
    for (k = 0; k < 4; k++) begin
      exp0.push_back(vals[k]);
      apb(8'h0c, 1'b1, {20'h0, vals[k]});
      exp1.push_back(~vals[k]);
      apb(8'h10, 1'b1, {20'h0, ~vals[k]});
    end
    apb(8'h00, 1'b1, 32'h100);
    @(negedge pclk);
    chk({31'h0, busy}, 32'h0);
    // both channels paced internally, rising trigger, interleaved
    apb(8'h00, 1'b1, 32'h03);
    apb(8'h08, 1'b1, 32'h50);
    for (k = 0; k < 4; k++) begin
      s[k] = 12'($random(seed));
      if (k % 2 == 0) exp0.push_back(s[k]);
      else exp1.push_back(s[k]);
      apb(8'h14, 1'b1, {20'h0, s[k]});
    end
    apb(8'h00, 1'b1, 32'h103);
    repeat (100) @(posedge pclk);
    src_u.trig_to(1'b1);
    apb(8'h04, 1'b0, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h4);
    chk({31'h0, refill_req}, 32'h1);
    drain();
    repeat (200) @(posedge pclk);
    chk({20'h0, dac0_code}, {20'h0, s[2]});
    apb(8'h00, 1'b1, 32'h200);
    @(negedge pclk);
    chk({31'h0, busy}, 32'h0);
    // channel 1 alone, external pace, falling trigger, finite run
    apb(8'h00, 1'b1, 32'h4e);
    for (k = 0; k < 2; k++) begin
      exp1.push_back(s[k] ^ 12'h0f0);
      apb(8'h14, 1'b1, {20'h0, s[k] ^ 12'h0f0});
    end
    apb(8'h00, 1'b1, 32'h14e);
    src_u.trig_to(1'b0);
    src_u.pace(3);
    drain();
    @(negedge pclk);
    chk({31'h0, busy}, 32'h0);
    // waveform replay on channel 0 wraps without gaps
    apb(8'h00, 1'b1, 32'h400);
    apb(8'h00, 1'b1, 32'h11);
    apb(8'h08, 1'b1, 32'h20);
    apb(8'h14, 1'b1, {20'h0, s[0]});
    apb(8'h14, 1'b1, {20'h0, s[1]});
    for (k = 0; k < 4; k++) exp0.push_back(s[k % 2]);
    apb(8'h00, 1'b1, 32'h111);
    src_u.trig_to(1'b1);
    drain();
    apb(8'h00, 1'b1, 32'h200);
    // synchronous update: both channels load in the same cycle
    apb(8'h00, 1'b1, 32'h42b);
    exp0.push_back(s[2]);
    exp1.push_back(s[3]);
    apb(8'h14, 1'b1, {20'h0, s[2]});
    apb(8'h14, 1'b1, {20'h0, s[3]});
    apb(8'h00, 1'b1, 32'h12b);
    src_u.trig_to(1'b0);
    for (k = 0; k < 1000 && dac1_load !== 1'b1; k++) @(posedge pclk);
    if (k == 1000) begin
      err_count++;
      conclude();
    end
    chk({31'h0, dac0_load}, 32'h1);
    apb(8'h00, 1'b1, 32'h200);
    drain();
    conclude();
  end
endmodule
